// file: verilog/rwpf_core.sv
// Rewriter flow-point tracking, forwarding changes and statistics gating
`timescale 1ns/1ns
// Contract
// - Flow points are ordered codes 0 (none) through 9 (register reply).
// - Software endpoint points by lookup; OAM points by OAM processor; reply by reply.
// - Each frame carries exactly one action: three inject, two extract, two loop, none.
// - Analyzer injections are cleared on entry: point and action become none.
// - Plain extract by lookup or MIP; up-endpoint extract only by OAM processor.
// - Queue loop counts as injection, assembler loop as extraction.
// - Queue-looped analyzer points translate to matching rewriter points.
// - CPU-injected frames keep their header point and action.
// - All forwarding changes and counting follow the frame's point and action.
// - With action none any later stage may overwrite point and action.
// - Injected at N: no changes or counting at points before N.
// - Extracted at N: no changes or counting at points after N.
// - Every frame walks all points; gating is purely logical.
// - A redirect or discard also updates the frame's point and action; copy does not.
// - Copy sends a CPU copy via loopback and forwards the original.
// - Redirect goes only to loopback, destination kept, MACs optionally swapped.
// - Redirect may deliver to a CPU queue, always through loopback.
// - Discard never transmits; no action leaves forwarding untouched.
// - Forward selector: 0 none, 1 copy, 2 redirect, 3 discard.
// - Redirect or discard is final; copy may escalate, CPU copy still delivered.
module rwpf_core #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_vld,
  input wire logic [3:0] in_pt,
  input wire logic [2:0] in_act,
  input wire logic in_from_cpu,
  input wire logic req_vld,
  input wire logic [1:0] req_src,
  input wire logic [1:0] req_sel,
  input wire logic req_loop,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic in_rdy_q,
  output logic walk_vld_q,
  output logic [3:0] walk_pt_q,
  output logic stat_inc_q,
  output logic out_vld_q,
  output logic out_tx_q,
  output logic out_lbk_q,
  output logic out_cpu_q,
  output logic out_swap_q,
  output logic [3:0] out_pt_q,
  output logic [2:0] out_act_q,
  output logic [31:0] reg_rdata_q
);
  typedef enum logic [0:0] {rwpf_idle, rwpf_walk} rwpf_state_t;

  rwpf_state_t state_q;
  logic [3:0] flow_pt_q;
  logic [2:0] flow_act_q;
  logic [1:0] fwd_q;
  logic cpu_q;
  logic lbk_q;
  logic [3:0] inj_stat_pt_q;
  logic [3:0] xtr_stat_pt_q;
  logic swap_ena_q;
  logic illegal_q;
  logic [CNT_W-1:0] stat_cnt_q;
  logic [CNT_W-1:0] drop_cnt_q;
  logic take;
  logic last_pt;
  logic [3:0] entry_pt;
  logic [2:0] entry_act;
  logic inj_type;
  logic xtr_type;
  logic allowed;
  logic src_ok;
  logic req_legal;
  logic req_change;
  logic sel_final;
  logic [2:0] new_act;
  logic [3:0] stat_pt;
  logic stat_hit;
  logic drop_done;
  logic [31:0] rd_mux_d;
  logic wr_ctrl;
  logic wr_status;
  logic illegal_set;

  // Entry normalisation of the carried point and action
  rwpf_entry u_entry (
    .in_pt(in_pt),
    .in_act(in_act),
    .from_cpu(in_from_cpu),
    .pt_o(entry_pt),
    .act_o(entry_act)
  );

  // Existence of the frame at the point now visited
  rwpf_gate u_gate (
    .flow_pt(flow_pt_q),
    .flow_act(flow_act_q),
    .at_pt(walk_pt_q),
    .inj_type(inj_type),
    .xtr_type(xtr_type),
    .allowed(allowed)
  );

  // Frame hand-off and walk bookkeeping
  assign take = in_vld && in_rdy_q;
  assign last_pt = (walk_pt_q == rwpf_pkg::register_reply_point);

  // Which party may act at which point
  assign src_ok =
    ((walk_pt_q == rwpf_pkg::inner_software_endpoint_point) ||
     (walk_pt_q == rwpf_pkg::outer_software_endpoint_point) ||
     (walk_pt_q == rwpf_pkg::service_test_point)) ? (req_src == rwpf_pkg::src_lookup) :
    ((walk_pt_q == rwpf_pkg::inner_service_oam_point) ||
     (walk_pt_q == rwpf_pkg::outer_service_oam_point) ||
     (walk_pt_q == rwpf_pkg::port_oam_point)) ? (req_src == rwpf_pkg::src_oam) :
    ((walk_pt_q == rwpf_pkg::inner_intermediate_point) ||
     (walk_pt_q == rwpf_pkg::outer_intermediate_point)) ? (req_src == rwpf_pkg::src_mip) :
    (walk_pt_q == rwpf_pkg::register_reply_point) ? (req_src == rwpf_pkg::src_reply) :
    1'b0;
  // Only the lookup loops frames back; replies carry no forwarding change
  assign req_legal = src_ok && !(req_loop && (req_src != rwpf_pkg::src_lookup)) &&
                     (req_src != rwpf_pkg::src_reply);
  // A settled redirect or discard is never reopened
  assign sel_final = (fwd_q == rwpf_pkg::fwd_redirect) || (fwd_q == rwpf_pkg::fwd_discard);
  assign req_change = walk_vld_q && req_vld && req_legal && allowed && !sel_final &&
                      (req_sel != rwpf_pkg::fwd_none);
  // Action stamped by a redirect or discard
  assign new_act = req_loop ? rwpf_pkg::assembler_loop_action :
                   (req_src == rwpf_pkg::src_oam) ? rwpf_pkg::extract_up_endpoint :
                   rwpf_pkg::extract_plain;

  // Statistics point depends on frame class
  assign stat_pt = xtr_type ? xtr_stat_pt_q : inj_stat_pt_q;
  assign stat_hit = walk_vld_q && allowed && (walk_pt_q == stat_pt);
  assign drop_done = walk_vld_q && last_pt && (fwd_q == rwpf_pkg::fwd_discard);
  assign illegal_set = walk_vld_q && req_vld && !req_legal;

  // Register decode
  assign wr_ctrl = reg_wr && (reg_addr == rwpf_pkg::reg_ctrl);
  assign wr_status = reg_wr && (reg_addr == rwpf_pkg::reg_status);
  assign rd_mux_d =
    (reg_addr == rwpf_pkg::reg_ctrl) ? {23'h000000, swap_ena_q, xtr_stat_pt_q, inj_stat_pt_q} :
    (reg_addr == rwpf_pkg::reg_status) ? {30'h00000000, illegal_q, walk_vld_q} :
    (reg_addr == rwpf_pkg::reg_stat_cnt) ? 32'(stat_cnt_q) :
    (reg_addr == rwpf_pkg::reg_drop_cnt) ? 32'(drop_cnt_q) :
    32'h00000000;

  // Walk sequencer: one point per cycle, every frame visits all nine
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= rwpf_idle;
      in_rdy_q <= 1'b1;
      walk_vld_q <= 1'b0;
      walk_pt_q <= rwpf_pkg::point_none;
    end else begin
      case (state_q)
        rwpf_idle: begin
          if (take) begin
            state_q <= rwpf_walk;
            in_rdy_q <= 1'b0;
            walk_vld_q <= 1'b1;
            walk_pt_q <= rwpf_pkg::inner_intermediate_point;
          end
        end
        rwpf_walk: begin
          if (last_pt) begin
            state_q <= rwpf_idle;
            in_rdy_q <= 1'b1;
            walk_vld_q <= 1'b0;
            walk_pt_q <= rwpf_pkg::point_none;
          end else begin
            walk_pt_q <= walk_pt_q + 4'h1;
          end
        end
        default: begin
          state_q <= rwpf_idle;
          in_rdy_q <= 1'b1;
          walk_vld_q <= 1'b0;
        end
      endcase
    end
  end

  // Per-frame point, action and forwarding state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flow_pt_q <= rwpf_pkg::point_none;
      flow_act_q <= rwpf_pkg::action_none;
      fwd_q <= rwpf_pkg::fwd_none;
      cpu_q <= 1'b0;
      lbk_q <= 1'b0;
    end else if (take) begin
      flow_pt_q <= entry_pt;
      flow_act_q <= entry_act;
      fwd_q <= rwpf_pkg::fwd_none;
      cpu_q <= 1'b0;
      lbk_q <= 1'b0;
    end else if (req_change) begin
      fwd_q <= req_sel;
      if (req_sel == rwpf_pkg::fwd_copy) begin
        cpu_q <= 1'b1;
      end else begin
        flow_pt_q <= walk_pt_q;
        flow_act_q <= new_act;
        if (req_sel == rwpf_pkg::fwd_redirect && req_loop) begin
          lbk_q <= 1'b1;
        end else if (req_sel == rwpf_pkg::fwd_redirect) begin
          cpu_q <= 1'b1;
        end
      end
    end
  end

  // Frame result, issued as the last point is left
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_vld_q <= 1'b0;
      out_tx_q <= 1'b0;
      out_lbk_q <= 1'b0;
      out_cpu_q <= 1'b0;
      out_swap_q <= 1'b0;
      out_pt_q <= rwpf_pkg::point_none;
      out_act_q <= rwpf_pkg::action_none;
    end else begin
      out_vld_q <= walk_vld_q && last_pt;
      if (walk_vld_q && last_pt) begin
        // Point 9 never changes forwarding, so fwd_q is final here
        out_tx_q <= (fwd_q == rwpf_pkg::fwd_none) || (fwd_q == rwpf_pkg::fwd_copy);
        out_lbk_q <= lbk_q || cpu_q;
        out_cpu_q <= cpu_q;
        out_swap_q <= lbk_q && swap_ena_q;
        out_pt_q <= flow_pt_q;
        out_act_q <= flow_act_q;
      end
    end
  end

  // Statistics strobe and counters
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_inc_q <= 1'b0;
      stat_cnt_q <= '0;
      drop_cnt_q <= '0;
    end else begin
      stat_inc_q <= stat_hit;
      if (stat_hit) begin
        stat_cnt_q <= stat_cnt_q + CNT_W'(1);
      end
      if (drop_done) begin
        drop_cnt_q <= drop_cnt_q + CNT_W'(1);
      end
    end
  end

  // Control register and sticky status; a new event beats the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      inj_stat_pt_q <= rwpf_pkg::inj_stat_rst;
      xtr_stat_pt_q <= rwpf_pkg::xtr_stat_rst;
      swap_ena_q <= rwpf_pkg::swap_rst;
      illegal_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        inj_stat_pt_q <= reg_wdata[rwpf_pkg::ctrl_inj_lsb +: 4];
        xtr_stat_pt_q <= reg_wdata[rwpf_pkg::ctrl_xtr_lsb +: 4];
        swap_ena_q <= reg_wdata[rwpf_pkg::ctrl_swap_bit];
      end
      if (illegal_set) begin
        illegal_q <= 1'b1;
      end else if (wr_status && reg_wdata[rwpf_pkg::status_illegal_bit]) begin
        illegal_q <= 1'b0;
      end
    end
  end

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_q <= 32'h00000000;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux_d : 32'h00000000;
    end
  end

  // Checks on the walk and the forwarding outcome
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence take_s;
    in_vld && in_rdy_q;
  endsequence
  sequence walk_s;
    (walk_vld_q && walk_pt_q == 4'h1) ##8 (walk_vld_q && walk_pt_q == 4'h9);
  endsequence

  walk_full_a: assert property (take_s |=> walk_s ##1 out_vld_q)
    else $error("frame did not visit all points");
  entry_clear_a: assert property (take_s ##0 ((in_act inside {3'h1, 3'h2, 3'h3}) &&
    !in_from_cpu) |=> flow_act_q == 3'h0 && flow_pt_q == 4'h0)
    else $error("analyzer injection not cleared");
  loop_xlate_a: assert property (take_s ##0 (in_act == 3'h7 && in_pt == 4'hc)
    |=> flow_pt_q == 4'h8)
    else $error("queue loop point not translated");
  inj_block_a: assert property (walk_vld_q && inj_type && walk_pt_q < flow_pt_q
    |=> $stable(flow_pt_q) && $stable(fwd_q) ##0 !stat_inc_q)
    else $error("injected frame changed before its point");
  xtr_block_a: assert property (walk_vld_q && xtr_type && walk_pt_q > flow_pt_q
    |=> $stable(flow_act_q) && $stable(fwd_q) && !stat_inc_q)
    else $error("extracted frame changed after its point");
  none_take_a: assert property (walk_vld_q && flow_act_q == 3'h0 && req_vld && req_legal &&
    req_sel == 2'h3 |=> flow_pt_q == $past(walk_pt_q) && fwd_q == 2'h3)
    else $error("free frame not overwritten");
  endpoint_src_a: assert property (walk_vld_q && req_vld && walk_pt_q == 4'h5 &&
    req_src != 2'h0 |=> $stable(fwd_q) && illegal_q)
    else $error("wrong party changed a lookup point");
  final_hold_a: assert property (walk_vld_q && sel_final && !last_pt
    |=> $stable(fwd_q) [*1] ##0 $stable(flow_pt_q))
    else $error("final forwarding reopened");
  discard_out_a: assert property (out_vld_q && fwd_q == 2'h3 |-> !out_tx_q)
    else $error("discarded frame transmitted");
  copy_out_a: assert property (out_vld_q && fwd_q == 2'h1 |-> out_tx_q && out_lbk_q && out_cpu_q)
    else $error("copy not both forwarded and looped");
  redir_out_a: assert property (out_vld_q && fwd_q == 2'h2
    |-> !out_tx_q && (out_lbk_q || out_cpu_q))
    else $error("redirect reached original port");
  stat_point_a: assert property (stat_inc_q |-> $past(walk_pt_q) == $past(stat_pt))
    else $error("statistic counted at wrong point");
  // Copy, loop, reply, walk-end and discard outcomes; copy must not move the frame's point
  copy_keep_a: assert property (walk_vld_q && flow_act_q == 3'h0 && req_vld && req_legal &&
    req_sel == 2'h1 |=> $stable(flow_pt_q) && $stable(flow_act_q) && cpu_q)
    else $error("copy changed point or action");
  loop_swap_a: assert property (out_vld_q && out_swap_q |-> out_lbk_q && !out_tx_q)
    else $error("swapped frame not a loop redirect");
  reply_keep_a: assert property (walk_vld_q && last_pt
    |=> $stable(fwd_q) && $stable(flow_act_q))
    else $error("reply point changed forwarding");
  idle_ready_a: assert property (out_vld_q
    |-> in_rdy_q && !walk_vld_q && walk_pt_q == 4'h0)
    else $error("walk not finished with the result");
  discard_cnt_a: assert property (walk_vld_q && last_pt && fwd_q == 2'h3
    |=> drop_cnt_q == $past(drop_cnt_q) + 1'b1)
    else $error("discarded frame not counted");
endmodule // rwpf_core

// file: verilog/rwpf_pkg.sv
// Shared codes, register map and reset values of the rewriter flow-point logic
package rwpf_pkg;
  // Flow points, ordered by position in the rewriter flow
  localparam logic [3:0] point_none = 4'h0;
  localparam logic [3:0] inner_intermediate_point = 4'h1;
  localparam logic [3:0] inner_software_endpoint_point = 4'h2;
  localparam logic [3:0] inner_service_oam_point = 4'h3;
  localparam logic [3:0] outer_service_oam_point = 4'h4;
  localparam logic [3:0] outer_software_endpoint_point = 4'h5;
  localparam logic [3:0] outer_intermediate_point = 4'h6;
  localparam logic [3:0] service_test_point = 4'h7;
  localparam logic [3:0] port_oam_point = 4'h8;
  localparam logic [3:0] register_reply_point = 4'h9;
  // Analyzer points carried by queue-looped frames
  localparam logic [3:0] analyzer_inner_oam_point = 4'ha;
  localparam logic [3:0] analyzer_outer_oam_point = 4'hb;
  localparam logic [3:0] analyzer_port_oam_point = 4'hc;
  // Flow actions
  localparam logic [2:0] action_none = 3'h0;
  localparam logic [2:0] inject_plain = 3'h1;
  localparam logic [2:0] inject_masquerade = 3'h2;
  localparam logic [2:0] inject_centralized = 3'h3;
  localparam logic [2:0] extract_plain = 3'h4;
  localparam logic [2:0] extract_up_endpoint = 3'h5;
  localparam logic [2:0] assembler_loop_action = 3'h6;
  localparam logic [2:0] queue_loop_action = 3'h7;
  // Forward selector codes
  localparam logic [1:0] fwd_none = 2'h0;
  localparam logic [1:0] fwd_copy = 2'h1;
  localparam logic [1:0] fwd_redirect = 2'h2;
  localparam logic [1:0] fwd_discard = 2'h3;
  // Who raises a request at a point
  localparam logic [1:0] src_lookup = 2'h0;
  localparam logic [1:0] src_mip = 2'h1;
  localparam logic [1:0] src_oam = 2'h2;
  localparam logic [1:0] src_reply = 2'h3;
  // Register map and fields
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_status = 8'h04;
  localparam logic [7:0] reg_stat_cnt = 8'h08;
  localparam logic [7:0] reg_drop_cnt = 8'h0c;
  localparam int ctrl_inj_lsb = 0;
  localparam int ctrl_xtr_lsb = 4;
  localparam int ctrl_swap_bit = 8;
  localparam int status_busy_bit = 0;
  localparam int status_illegal_bit = 1;
  localparam logic [3:0] inj_stat_rst = 4'h8;
  localparam logic [3:0] xtr_stat_rst = 4'h5;
  localparam logic swap_rst = 1'b1;
endpackage

// file: verilog/rwpf_gate.sv
// Decides whether a frame logically exists at a given flow point
`timescale 1ns/1ns
module rwpf_gate (
  input wire logic [3:0] flow_pt,
  input wire logic [2:0] flow_act,
  input wire logic [3:0] at_pt,
  output logic inj_type,
  output logic xtr_type,
  output logic allowed
);
  // Queue loop behaves as injection, assembler loop as extraction
  assign inj_type = (flow_act == rwpf_pkg::inject_plain) ||
                    (flow_act == rwpf_pkg::inject_masquerade) ||
                    (flow_act == rwpf_pkg::inject_centralized) ||
                    (flow_act == rwpf_pkg::queue_loop_action);
  assign xtr_type = (flow_act == rwpf_pkg::extract_plain) ||
                    (flow_act == rwpf_pkg::extract_up_endpoint) ||
                    (flow_act == rwpf_pkg::assembler_loop_action);
  // Blocked before an injection point, after an extraction point
  assign allowed = inj_type ? (at_pt >= flow_pt) :
                   xtr_type ? (at_pt <= flow_pt) :
                   1'b1;
endmodule // rwpf_gate

// file: verilog/rwpf_entry.sv
// Normalises the flow point and action a frame carries into the rewriter
`timescale 1ns/1ns
module rwpf_entry (
  input wire logic [3:0] in_pt,
  input wire logic [2:0] in_act,
  input wire logic from_cpu,
  output logic [3:0] pt_o,
  output logic [2:0] act_o
);
  logic analyzer_inject;
  logic [3:0] loop_pt;
  // Analyzer injections are dropped; CPU header values are kept
  assign analyzer_inject = !from_cpu && ((in_act == rwpf_pkg::inject_plain) ||
                           (in_act == rwpf_pkg::inject_masquerade) ||
                           (in_act == rwpf_pkg::inject_centralized));
  // Analyzer points map to where the frame reappears in the rewriter
  assign loop_pt = (in_pt == rwpf_pkg::analyzer_port_oam_point) ? rwpf_pkg::port_oam_point :
                   (in_pt == rwpf_pkg::analyzer_outer_oam_point) ? rwpf_pkg::outer_service_oam_point :
                   (in_pt == rwpf_pkg::analyzer_inner_oam_point) ? rwpf_pkg::inner_service_oam_point :
                   in_pt;
  assign act_o = analyzer_inject ? rwpf_pkg::action_none : in_act;
  assign pt_o = analyzer_inject ? rwpf_pkg::point_none :
                (in_act == rwpf_pkg::queue_loop_action) ? loop_pt : in_pt;
endmodule // rwpf_entry

// file: bench/rwpf_src_model.sv
// Behavioural upstream: analyzer, queue system and CPU injection feeding the rewriter
`timescale 1ns/1ns
module rwpf_src_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic go,
  input wire logic [3:0] lag,
  input wire logic [3:0] d_pt,
  input wire logic [2:0] d_act,
  input wire logic d_cpu,
  input wire logic [9:0] r_en,
  input wire logic [19:0] r_src,
  input wire logic [19:0] r_sel,
  input wire logic [9:0] r_loop,
  input wire logic in_rdy_q,
  input wire logic walk_vld_q,
  input wire logic [3:0] walk_pt_q,
  output logic in_vld,
  output logic [3:0] in_pt,
  output logic [2:0] in_act,
  output logic in_from_cpu,
  output logic req_vld,
  output logic [1:0] req_src,
  output logic [1:0] req_sel,
  output logic req_loop
);
  logic [3:0] wait_q;
  logic pend_q;
  logic [1:0] src_w;
  logic [1:0] sel_w;

  // Offer held until the rewriter takes it; lag models a slow source
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend_q <= 1'b0;
      wait_q <= 4'h0;
      in_vld <= 1'b0;
    end else if (go) begin
      pend_q <= 1'b1;
      wait_q <= lag;
    end else if (pend_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (pend_q && !in_vld) begin
      in_vld <= 1'b1;
    end else if (in_vld && in_rdy_q) begin
      in_vld <= 1'b0;
      pend_q <= 1'b0;
    end
  end

  // Descriptor fields scrambled when not offered, so stale values never look valid
  assign in_pt = in_vld ? d_pt : ~d_pt;
  assign in_act = in_vld ? d_act : ~d_act;
  assign in_from_cpu = in_vld ? d_cpu : ~d_cpu;

  // Each stage answers in the cycle its point is visited
  assign src_w = r_src[2 * walk_pt_q +: 2];
  assign sel_w = r_sel[2 * walk_pt_q +: 2];
  assign req_vld = walk_vld_q && (walk_pt_q <= 4'h9) && r_en[walk_pt_q];
  assign req_src = req_vld ? src_w : ~src_w;
  assign req_sel = req_vld ? sel_w : ~sel_w;
  assign req_loop = req_vld ? r_loop[walk_pt_q] : 1'b0;
endmodule // rwpf_src_model

// file: bench/tb.sv
// Self-checking bench for the rewriter flow-point logic
`timescale 1ns/1ns
module tb;
  logic clk_sys, srst, go, d_cpu, reg_wr, reg_rd;
  logic [3:0] lag, d_pt;
  logic [2:0] d_act;
  logic [9:0] r_en, r_loop;
  logic [19:0] r_src, r_sel;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, rd;
  logic in_vld, in_from_cpu, req_vld, req_loop, in_rdy_q, walk_vld_q, stat_inc_q;
  logic out_vld_q, out_tx_q, out_lbk_q, out_cpu_q, out_swap_q;
  logic [3:0] in_pt, walk_pt_q, out_pt_q;
  logic [2:0] in_act, out_act_q;
  logic [1:0] req_src, req_sel;
  logic [31:0] reg_rdata_q;
  logic [3:0] tr [3] = '{4'h3, 4'h4, 4'h8};
  int miscompares, n_tests, cycles;

  rwpf_src_model i_rwpf_src_model (.clk_sys(clk_sys), .srst(srst), .go(go), .lag(lag),
    .d_pt(d_pt), .d_act(d_act), .d_cpu(d_cpu), .r_en(r_en), .r_src(r_src), .r_sel(r_sel),
    .r_loop(r_loop), .in_rdy_q(in_rdy_q), .walk_vld_q(walk_vld_q), .walk_pt_q(walk_pt_q),
    .in_vld(in_vld), .in_pt(in_pt), .in_act(in_act), .in_from_cpu(in_from_cpu),
    .req_vld(req_vld), .req_src(req_src), .req_sel(req_sel), .req_loop(req_loop));

  rwpf_core i_rwpf_core (.clk_sys(clk_sys), .srst(srst), .in_vld(in_vld), .in_pt(in_pt),
    .in_act(in_act), .in_from_cpu(in_from_cpu), .req_vld(req_vld), .req_src(req_src),
    .req_sel(req_sel), .req_loop(req_loop), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .in_rdy_q(in_rdy_q), .walk_vld_q(walk_vld_q),
    .walk_pt_q(walk_pt_q), .stat_inc_q(stat_inc_q), .out_vld_q(out_vld_q),
    .out_tx_q(out_tx_q), .out_lbk_q(out_lbk_q), .out_cpu_q(out_cpu_q),
    .out_swap_q(out_swap_q), .out_pt_q(out_pt_q), .out_act_q(out_act_q),
    .reg_rdata_q(reg_rdata_q));

  // Free-running 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check("read data", reg_rdata_q, exp);
  endtask

  task automatic add_req(input int p, input logic [1:0] s, input logic [1:0] f, input logic l);
    r_en[p] = 1'b1;
    r_src[2 * p +: 2] = s;
    r_sel[2 * p +: 2] = f;
    r_loop[p] = l;
  endtask

  // One frame: exp is {tx, lbk, cpu, swap, point, action}; es < 0 skips the count check
  task automatic run(input logic [3:0] p, input logic [2:0] a, input logic c,
                     input logic [3:0] l, input logic [10:0] exp, input int es);
    int k;
    int st;
    int wk;
    @(posedge clk_sys);
    d_pt <= p;
    d_act <= a;
    d_cpu <= c;
    lag <= l;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    st = 0;
    wk = 0;
    for (k = 0; k < 40 && out_vld_q !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
      st += (stat_inc_q === 1'b1);
      wk += (walk_vld_q === 1'b1);
    end
    check("frame result", {out_tx_q, out_lbk_q, out_cpu_q, out_swap_q, out_pt_q, out_act_q},
          exp);
    check("points walked", wk, 9);
    check("idle after frame", {in_rdy_q, walk_pt_q}, {1'b1, 4'h0});
    if (es >= 0) begin
      check("stat pulses", st, es);
    end
    r_en = 10'h000;
  endtask

  // Main sequence
  initial begin
    srst = 1'b1;
    {go, d_cpu, reg_wr, reg_rd, lag, d_pt, d_act, reg_addr, reg_wdata} = '0;
    {r_en, r_loop, r_src, r_sel} = '0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    reg_read(8'h00, 32'h0000_0158);
    reg_read(8'h10, 32'h0000_0000);
    reg_write(8'h10, 32'hffff_ffff);
    reg_read(8'h00, 32'h0000_0158);
    run(4'h0, 3'h0, 1'b0, 4'h0, {4'h8, 4'h0, 3'h0}, 1);
    add_req(5, 2'h0, 2'h2, 1'b1);
    run(4'h0, 3'h0, 1'b0, 4'h3, {4'h5, 4'h5, 3'h6}, -1);
    for (int a = 1; a <= 3; a++) begin
      add_req(2, 2'h0, 2'h1, 1'b0);
      run(4'h3, 3'(a), 1'b0, 4'h0, {4'he, 4'h0, 3'h0}, 1);
      add_req(1, 2'h1, 2'h3, 1'b0);
      run(4'h3, 3'(a), 1'b1, 4'h2, {4'h8, 4'h3, 3'(a)}, 1);
    end
    add_req(7, 2'h0, 2'h2, 1'b1);
    run(4'h9, 3'h1, 1'b1, 4'h0, {4'h8, 4'h9, 3'h1}, 0);
    for (int a = 4; a <= 5; a++) begin
      add_req(7, 2'h0, 2'h2, 1'b1);
      run(4'h1, 3'(a), 1'b1, 4'h1, {4'h8, 4'h1, 3'(a)}, 0);
    end
    for (int i = 0; i < 3; i++) begin
      add_req(2, 2'h0, 2'h2, 1'b1);
      run(4'ha + 4'(i), 3'h7, 1'b0, 4'h0, {4'h8, tr[i], 3'h7}, -1);
    end
    add_req(2, 2'h0, 2'h1, 1'b0);
    add_req(5, 2'h0, 2'h3, 1'b0);
    add_req(7, 2'h0, 2'h2, 1'b1);
    run(4'h0, 3'h0, 1'b0, 4'h0, {4'h6, 4'h5, 3'h4}, -1);
    add_req(4, 2'h2, 2'h2, 1'b0);
    run(4'h0, 3'h0, 1'b0, 4'h0, {4'h6, 4'h4, 3'h5}, -1);
    add_req(6, 2'h1, 2'h2, 1'b0);
    run(4'h0, 3'h0, 1'b0, 4'h0, {4'h6, 4'h6, 3'h4}, -1);
    reg_read(8'h04, 32'h0000_0000);
    add_req(5, 2'h1, 2'h3, 1'b0);
    add_req(6, 2'h0, 2'h3, 1'b0);
    run(4'h0, 3'h0, 1'b0, 4'h0, {4'h8, 4'h0, 3'h0}, -1);
    reg_read(8'h04, 32'h0000_0002);
    reg_write(8'h04, 32'h0000_0002);
    reg_read(8'h04, 32'h0000_0000);
    reg_read(8'h0c, 32'h0000_0001);
    reg_read(8'h08, 32'h0000_000b);
    reg_write(8'h00, 32'h0000_0058);
    reg_read(8'h00, 32'h0000_0058);
    add_req(5, 2'h0, 2'h2, 1'b1);
    run(4'h0, 3'h0, 1'b0, 4'h0, {4'h4, 4'h5, 3'h6}, -1);
    wrap_up();
  end
endmodule // tb
